// >>> ups_pkg.sv
package ups_pkg;

  // avalon byte offsets
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_CLASS  = 5'h04;
  localparam logic [4:0] OFS_MAP    = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;
  localparam logic [4:0] OFS_RX_RES = 5'h10;
  localparam logic [4:0] OFS_TX_RES = 5'h14;

  // field positions
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_MUX_BIT  = 1;
  localparam int CLASS0_LSB    = 0;
  localparam int CLASS1_LSB    = 8;
  localparam int CLASS2_LSB    = 16;
  localparam int ST_RX_ACT_BIT = 0;
  localparam int ST_RX_SEL_LSB = 8;
  localparam int ST_TX_ACT_BIT = 16;
  localparam int ST_TX_SEL_LSB = 24;

  // reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] CLASS_RST = 32'h0005_0505;
  localparam logic [31:0] MAP_RST   = 32'h0000_0000;

  // address space
  localparam logic [4:0] NULL_ADDR     = 5'h1F;
  localparam logic [3:0] NULL_NIBBLE   = 4'hF;
  localparam logic [4:0] PHYS_15       = 5'd15;
  localparam logic [4:0] PHYS_MUX      = 5'd30;
  localparam logic [4:0] POLL_LAST_15  = 5'h0E;
  localparam logic [4:0] POLL_LAST_MUX = 5'h07;
  localparam int         NUM_PHY       = 30;
  localparam int         NUM_LANE      = 4;

  // cell timing in link clocks, 8-bit cell bus
  localparam logic [6:0] CELL_CLKS = 7'd53;
  localparam logic [6:0] LAST_SLOT = CELL_CLKS - 7'd1;

  // class rotation, six slots: 0,1,0,1,0,2
  localparam logic [2:0] ROT_LEN = 3'd6;
  localparam logic [11:0] ROT_PATTERN = 12'h844;

  typedef enum logic [1:0] {
    PH_CELL,
    PH_GAP,
    PH_RPA,
    PH_SA
  } ups_phase_type;

  typedef enum logic [1:0] {
    SK_POLL,
    SK_RPA,
    SK_SEL,
    SK_NONE
  } ups_slot_type;

endpackage

// >>> ups_poll_select.sv
`timescale 1ns/100ps
// Behaviour
// RL1: 15-PHY mode polls addresses 0h to Eh
// RL2: unmapped poll address is driven as Fh
// RL3: selected PHY polled as Fh while receiving; mux mode nulls its group only when the selected PHY is on lane 0
// RL4: dedicated poll slot for the receiving PHY
// RL5: selection slot answer never stored in results
// RL6: scan results upward from check start address
// RL7: three consecutive classes; start rotates between them
// RL8: six-slot rotation, classes get 3/2/1 slots
// RL9: enable held for whole cell; reselect back-to-back
// RL10: enable off at last payload; Fh adds gap
// RL11: transmit enable held for the entire cell
// RL12: transmit poll sequence matches the receive side
// RL13: transmit poll slot for current PHY, else Fh
// RL14: transmit selection answer never stored in results
// RL15: mux mode: four lanes, lane is address[1:0]
// RL16: mux mode polls 00h,04h..1Ch repeatedly
// RL17: mux mode scans thirty PHYs 00h to 1Dh
// RL18: mux mode rotates class start over thirty
// RL19: mux mode drops all lanes at selection slot
// RL20: nothing ready: drive Fh, enable stays off
module ups_poll_select (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_clk_en,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_rx_cell_bus_clock,
  input  wire logic [3:0]  i_rx_cell_available,
  output logic      [4:0]  o_rx_phy_address_bus,
  output logic             o_receive_enable_low,
  input  wire logic        i_tx_cell_bus_clock,
  input  wire logic [3:0]  i_tx_cell_available,
  input  wire logic [29:0] i_tx_cell_queued,
  output logic      [4:0]  o_tx_phy_address_bus,
  output logic             o_transmit_enable_low
);
  import ups_pkg::*;

  logic [31:0] ctrl_q;
  logic [31:0] class_q;
  logic [31:0] map_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [29:0] queued_q;
  logic        run;
  logic        mux;
  logic [4:0]  nphy;
  logic [31:0] map_ext;

  // per-direction wiring, index 0 receive, 1 transmit
  logic        link_clk  [2];
  logic [3:0]  clav_in   [2];
  logic [29:0] gate      [2];
  logic [4:0]  addr_q    [2];
  logic        enl_q     [2];
  logic        active_q  [2];
  logic [4:0]  sel_q     [2];
  logic [29:0] result_q  [2];

  // control decode
  assign run     = ctrl_q[CTRL_RUN_BIT];
  assign mux     = ctrl_q[CTRL_MUX_BIT];
  assign nphy    = mux ? PHYS_MUX : PHYS_15;
  assign map_ext = {2'b00, map_q[29:0]};

  assign link_clk[0] = i_rx_cell_bus_clock;
  assign link_clk[1] = i_tx_cell_bus_clock;
  assign clav_in[0]  = i_rx_cell_available;
  assign clav_in[1]  = i_tx_cell_available;
  assign gate[0]     = map_q[29:0];
  assign gate[1]     = map_q[29:0] & queued_q;

  // link outputs come straight from the per-direction flops
  assign o_rx_phy_address_bus  = addr_q[0];
  assign o_receive_enable_low  = enl_q[0];
  assign o_tx_phy_address_bus  = addr_q[1];
  assign o_transmit_enable_low = enl_q[1];

  // merge a write under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // first ready PHY at or above start, wrapping inside n
  function automatic logic [5:0] scan(input logic [29:0] ready, input logic [4:0] start,
                                      input logic [4:0] n);
    logic [5:0] r;
    logic [5:0] idx;
    r = {1'b0, NULL_ADDR};
    for (int i = NUM_PHY - 1; i >= 0; i--) begin
      idx = {1'b0, start} + 6'(i);
      if (idx >= {1'b0, n}) begin
        idx = idx - {1'b0, n};
      end
      if ((6'(i) < {1'b0, n}) && ready[idx[4:0]]) begin
        r = {1'b1, idx[4:0]};
      end
    end
    return r;
  endfunction

  // polling counter value to bus address
  function automatic logic [4:0] poll_value(input logic [4:0] cnt, input logic m);
    return m ? {cnt[2:0], 2'b00} : cnt; // [RL1] [RL16]
  endfunction

  // avalon slave: one wait state, answer on the second edge
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ack_q <= 1'b0;
    end else if (i_clk_en) begin
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
    end
  end

  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;

  // read data captured on the first edge of the request
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_clk_en && i_avs_read && !ack_q) begin
      unique case (i_avs_address)
        OFS_CTRL:   rdata_q <= ctrl_q;
        OFS_CLASS:  rdata_q <= class_q;
        OFS_MAP:    rdata_q <= map_q;
        OFS_STATUS: begin
          rdata_q <= 32'h0000_0000;
          rdata_q[ST_RX_ACT_BIT] <= active_q[0];
          rdata_q[ST_RX_SEL_LSB +: 5] <= sel_q[0];
          rdata_q[ST_TX_ACT_BIT] <= active_q[1];
          rdata_q[ST_TX_SEL_LSB +: 5] <= sel_q[1];
        end
        OFS_RX_RES: rdata_q <= {2'b00, result_q[0]};
        OFS_TX_RES: rdata_q <= {2'b00, result_q[1]};
        default:    rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // read data stands from its loading edge until the next read
  assign o_avs_readdata = rdata_q;

  // configuration writes take effect on the accepting edge
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ctrl_q  <= CTRL_RST;
      class_q <= CLASS_RST;
      map_q   <= MAP_RST;
    end else if (i_clk_en && i_avs_write && ack_q) begin
      if (i_avs_address == OFS_CTRL) begin
        ctrl_q <= be_merge(ctrl_q, i_avs_writedata, i_avs_byteenable) & 32'h0000_0003;
      end
      if (i_avs_address == OFS_CLASS) begin
        class_q <= be_merge(class_q, i_avs_writedata, i_avs_byteenable) & 32'h001F_1F1F;
      end
      if (i_avs_address == OFS_MAP) begin
        map_q <= be_merge(map_q, i_avs_writedata, i_avs_byteenable) & 32'h3FFF_FFFF;
      end
    end
  end

  // queue flags come from same-clock logic, registered once for timing
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      queued_q <= 30'h0000_0000;
    end else if (i_clk_en) begin
      queued_q <= i_tx_cell_queued;
    end
  end

  for (genvar d = 0; d < 2; d++) begin : g_dir
    logic [2:0]    clk_sync_q;
    logic [3:0]    clav_s1_q;
    logic [3:0]    clav_s2_q;
    logic          tick;
    ups_phase_type phase_q;
    ups_slot_type  prev_kind_q;
    logic [4:0]    prev_addr_q;
    logic [6:0]    pos_q;
    logic [4:0]    pcnt_q;
    logic [2:0]    rot_q;
    logic [4:0]    ptr_q [3];
    logic [4:0]    pa_raw;
    logic [4:0]    pa_val;
    logic          pa_mapped;
    logic [1:0]    cls;
    logic [4:0]    cls_cnt;
    logic [4:0]    cls_base;
    logic [4:0]    cstart;
    logic [5:0]    pick;

    // link clock and lanes cross in two flops; the third flop only feeds edge detect
    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
        clk_sync_q <= 3'b000;
        clav_s1_q  <= 4'h0;
        clav_s2_q  <= 4'h0;
      end else if (i_clk_en) begin
        clk_sync_q <= {clk_sync_q[1:0], link_clk[d]};
        clav_s1_q  <= clav_in[d];
        clav_s2_q  <= clav_s1_q;
      end
    end

    // one tick per link rising edge; clock enable low stalls the slot engine
    // with it, so a frozen block never skips a slot
    assign tick = i_clk_en & clk_sync_q[1] & ~clk_sync_q[2];

    // poll address for this slot with both substitutions
    always_comb begin
      pa_raw    = poll_value(pcnt_q, mux);
      pa_mapped = mux ? (|map_ext[pa_raw +: NUM_LANE]) : map_ext[pa_raw];
      pa_val    = pa_raw;
      if (!pa_mapped) begin
        pa_val = NULL_ADDR; // [RL2]
      end else if (enl_q[d] && (pa_raw == sel_q[d])) begin
        pa_val = NULL_ADDR; // [RL3] [RL12]
      end
    end

    // check start: class from the six-slot pattern, pointer inside class
    always_comb begin
      cls      = ROT_PATTERN[rot_q*2 +: 2]; // [RL8]
      cls_cnt  = class_q[CLASS0_LSB +: 5];
      cls_base = 5'd0;
      if (cls == 2'd1) begin
        cls_cnt  = class_q[CLASS1_LSB +: 5];
        cls_base = class_q[CLASS0_LSB +: 5];
      end else if (cls == 2'd2) begin
        cls_cnt  = class_q[CLASS2_LSB +: 5];
        cls_base = class_q[CLASS0_LSB +: 5] + class_q[CLASS1_LSB +: 5];
      end
      cstart = cls_base + ptr_q[cls]; // [RL7] [RL18]
      if (cls_cnt == 5'd0 || cstart >= nphy) begin
        cstart = 5'd0; // empty or oversized class falls back to the bottom
      end
      pick = scan(result_q[d] & gate[d], cstart, nphy); // [RL6] [RL17]
    end

    // stored polling results, written one link clock after the address
    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || !run) begin
        result_q[d] <= 30'h0000_0000;
      end else if (tick && prev_kind_q != SK_SEL && prev_kind_q != SK_NONE
                   && prev_addr_q != NULL_ADDR) begin // [RL5] [RL14] [RL19]
        if (mux) begin
          // a group poll fills four results, only two for 1Ch; a single-PHY poll only its own lane
          for (int k = 0; k < NUM_LANE; k++) begin
            if (int'(prev_addr_q[4:2]) * NUM_LANE + k < NUM_PHY
                && (prev_kind_q == SK_POLL || prev_addr_q[1:0] == 2'(k))) begin
              result_q[d][int'(prev_addr_q[4:2]) * NUM_LANE + k] <= clav_s2_q[k]; // [RL15]
            end
          end
        end else begin
          result_q[d][prev_addr_q] <= clav_s2_q[0];
        end
      end
    end

    // class rotation advances once per selection slot
    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || !run) begin
        rot_q <= 3'd0;
        ptr_q <= '{default: 5'd0};
      end else if (tick && phase_q == PH_SA) begin
        rot_q <= (rot_q == ROT_LEN - 3'd1) ? 3'd0 : rot_q + 3'd1;
        ptr_q[cls] <= (ptr_q[cls] + 5'd1 >= cls_cnt) ? 5'd0 : ptr_q[cls] + 5'd1; // [RL7]
      end
    end

    // slot engine: cell slots, optional gap, poll of current PHY, selection
    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || !run) begin
        phase_q     <= PH_CELL;
        prev_kind_q <= SK_NONE;
        prev_addr_q <= NULL_ADDR;
        pos_q       <= 7'd0;
        pcnt_q      <= 5'd0;
        addr_q[d]   <= NULL_ADDR;
        enl_q[d]    <= 1'b0;
        active_q[d] <= 1'b0;
        sel_q[d]    <= NULL_ADDR;
      end else if (tick) begin
        unique case (phase_q)
          PH_CELL, PH_GAP: begin
            addr_q[d]   <= pa_val;
            prev_addr_q <= pa_val;
            prev_kind_q <= SK_POLL;
            // a mode change mid-sequence must not walk the counter past the end
            pcnt_q <= (pcnt_q >= (mux ? POLL_LAST_MUX : POLL_LAST_15)) ? 5'd0
                      : pcnt_q + 5'd1; // [RL1] [RL16]
            if (phase_q == PH_GAP) begin
              phase_q <= PH_RPA;
            end else if (pos_q == LAST_SLOT) begin
              enl_q[d] <= 1'b0; // [RL10]
              pos_q    <= 7'd0;
              phase_q  <= (pa_val[3:0] == NULL_NIBBLE) ? PH_GAP : PH_RPA; // [RL10]
            end else begin
              enl_q[d] <= active_q[d]; // [RL9] [RL11]
              pos_q    <= pos_q + 7'd1;
            end
          end
          PH_RPA: begin
            addr_q[d]   <= active_q[d] ? sel_q[d] : NULL_ADDR; // [RL4] [RL13]
            prev_addr_q <= active_q[d] ? sel_q[d] : NULL_ADDR;
            prev_kind_q <= SK_RPA;
            phase_q     <= PH_SA;
          end
          PH_SA: begin
            prev_kind_q <= SK_SEL;
            prev_addr_q <= NULL_ADDR;
            phase_q     <= PH_CELL;
            active_q[d] <= pick[5]; // [RL20]
            if (pick[5]) begin
              addr_q[d] <= pick[4:0]; // [RL6] [RL9]
              sel_q[d]  <= pick[4:0];
            end else begin
              addr_q[d] <= NULL_ADDR; // [RL20]
            end
          end
        endcase
      end
    end
  end

endmodule

// >>> ups_poll_select_props.sv
`timescale 1ns/100ps
module ups_poll_select_props (
  input wire logic       i_ref_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_avs_read,
  input wire logic       i_avs_write,
  input wire logic       o_avs_waitrequest,
  input wire logic [4:0] o_rx_phy_address_bus,
  input wire logic       o_receive_enable_low,
  input wire logic [4:0] o_tx_phy_address_bus,
  input wire logic       o_transmit_enable_low
);
  int rn_q;
  int tn_q;
  // cycles the receive enable has been held
  always_ff @(posedge i_ref_clk) begin
    rn_q <= (i_sys_rst || !o_receive_enable_low) ? 0 : rn_q + 1;
  end
  // cycles the transmit enable has been held
  always_ff @(posedge i_ref_clk) begin
    tn_q <= (i_sys_rst || !o_transmit_enable_low) ? 0 : tn_q + 1;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // 52 link ticks of 8 clocks, one link tick of slack either way
  rx_cell_len_a:
    assert property ($fell(o_receive_enable_low) |-> rn_q inside {[408:424]})
    else $error("rx enable length wrong");
  tx_cell_len_a:
    assert property ($fell(o_transmit_enable_low) |-> tn_q inside {[408:424]})
    else $error("tx enable length wrong");
  rx_cell_gap_a:
    assert property ($fell(o_receive_enable_low) |=> !o_receive_enable_low [*8])
    else $error("rx reselect gap too short");
  tx_cell_gap_a:
    assert property ($fell(o_transmit_enable_low) |=> !o_transmit_enable_low [*8])
    else $error("tx reselect gap too short");
  rx_addr_hold_a:
    assert property ($changed(o_rx_phy_address_bus) |=> $stable(o_rx_phy_address_bus) [*5])
    else $error("rx address not held a link period");
  tx_addr_hold_a:
    assert property ($changed(o_tx_phy_address_bus) |=> $stable(o_tx_phy_address_bus) [*5])
    else $error("tx address not held a link period");
  rst_idle_a:
    assert property ($fell(i_sys_rst) |-> o_rx_phy_address_bus == 5'h1F && !o_receive_enable_low)
    else $error("not idle after reset");
  bus_wait_a:
    assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus answer late");
  rx_cell_c: cover property ($fell(o_receive_enable_low));
  tx_cell_c: cover property ($fell(o_transmit_enable_low));
  bus_read_c: cover property (i_avs_read && !o_avs_waitrequest);
endmodule

bind ups_poll_select ups_poll_select_props u_props (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .o_rx_phy_address_bus(o_rx_phy_address_bus), .o_receive_enable_low(o_receive_enable_low),
  .o_tx_phy_address_bus(o_tx_phy_address_bus), .o_transmit_enable_low(o_transmit_enable_low));

// >>> ups_phy_model.sv
`timescale 1ns/100ps
module ups_phy_model #(
  parameter real OFS = 37.3
) (
  input  wire logic        i_mux,
  input  wire logic        i_clr,
  input  wire logic [4:0]  i_adr,
  input  wire logic        i_en,
  input  wire logic [29:0] i_rdy,
  output logic             o_clk,
  output logic      [3:0]  o_clav,
  output logic      [31:0] o_seen,
  output logic      [29:0] o_hits
);
  import ups_pkg::*;
  logic [4:0] sa_q;
  logic       en_q;
  // free-running link clock, phase unrelated to the system clock
  initial begin
    o_clk = 1'b0;
    o_clav = 4'h0;
    #(OFS);
    forever #100 o_clk = ~o_clk;
  end
  // phys answer the address on the wire; an undriven lane shows its inverse
  always @(posedge o_clk) begin
    int idx;
    for (int k = 0; k < 4; k++) begin
      idx = i_mux ? int'({i_adr[4:2], 2'b00}) + k : int'(i_adr);
      if (i_adr == NULL_ADDR || (k > 0 && !i_mux) || idx > 29) o_clav[k] <= ~o_clav[k];
      else o_clav[k] <= i_rdy[idx];
    end
  end
  // addresses seen on the wire, and which phy got each cell
  always @(posedge o_clk) begin
    en_q <= i_en;
    sa_q <= i_adr;
    if (i_clr) begin
      o_seen <= '0;
      o_hits <= '0;
    end else begin
      o_seen[i_adr] <= 1'b1;
      if (i_en && !en_q && sa_q < 5'd30) o_hits[sa_q] <= 1'b1;
    end
  end
endmodule

// >>> ups_poll_select_tb.sv
`timescale 1ns/100ps
module ups_poll_select_tb;
  import ups_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        mux = 1'b0;
  logic        clr = 1'b0;
  logic [4:0]  adr = '0;
  logic [31:0] wd = '0;
  logic [29:0] rxr = '0;
  logic [29:0] txr = '0;
  logic [29:0] qd = '0;
  logic [31:0] rdat, q, rxs, txs;
  logic [29:0] rxh, txh;
  logic [4:0]  rxa, txa;
  logic [3:0]  rxv, txv;
  logic        wreq, rxc, txc, rxe, txe;
  logic [4:0]  row_a [6];
  logic [31:0] row_d [6];
  int          error_cnt = 0;
  int          compares = 0;

  always #12.5 clk = ~clk;

  ups_poll_select uut (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(1'b1), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_rx_cell_bus_clock(rxc),
    .i_rx_cell_available(rxv), .o_rx_phy_address_bus(rxa), .o_receive_enable_low(rxe),
    .i_tx_cell_bus_clock(txc), .i_tx_cell_available(txv), .i_tx_cell_queued(qd),
    .o_tx_phy_address_bus(txa), .o_transmit_enable_low(txe));
  // one phy population on each direction, clocks out of phase
  ups_phy_model #(.OFS(37.3)) u_rx (.i_mux(mux), .i_clr(clr), .i_adr(rxa), .i_en(rxe),
    .i_rdy(rxr), .o_clk(rxc), .o_clav(rxv), .o_seen(rxs), .o_hits(rxh));
  ups_phy_model #(.OFS(91.7)) u_tx (.i_mux(mux), .i_clr(clr), .i_adr(txa), .i_en(txe),
    .i_rdy(txr), .o_clk(txc), .o_clav(txv), .o_seen(txs), .o_hits(txh));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one bus access; waitrequest and read data are taken at the same rising edge
  task automatic avs(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wreq !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) error_cnt++;
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // clear the trackers, then let traffic flow
  task automatic run(input int cyc);
    clr <= 1'b1;
    repeat (20) @(posedge clk);
    clr <= 1'b0;
    repeat (cyc) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog, about three times the expected run
  initial begin
    #1000000;
    error_cnt++;
    wrap_up();
  end
  // main sequence
  initial begin
    row_a = '{OFS_CTRL, OFS_CLASS, OFS_MAP, 5'h18, OFS_RX_RES, OFS_TX_RES};
    row_d = '{CTRL_RST, CLASS_RST, MAP_RST, 32'h0, 32'h0, 32'h0};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (row_a[i]) begin
      avs(1'b0, row_a[i], '0);
      chk("reg read", row_d[i], q);
    end
    avs(1'b1, 5'h18, 32'hFFFF_FFFF);
    avs(1'b0, 5'h18, '0);
    chk("unmapped", 32'h0, q);
    avs(1'b1, OFS_MAP, 32'h0000_0208);
    avs(1'b1, OFS_CTRL, 32'h0000_0001);
    run(600);
    chk("rx seen", 32'h8000_0208, rxs);
    chk("tx seen", 32'h8000_0208, txs);
    chk("rx idle", 32'h0, {2'b0, rxh});
    rxr <= 30'h208;
    txr <= 30'h208;
    run(4000);
    chk("rx pick", 32'h208, {2'b0, rxh});
    chk("tx unqueued", 32'h0, {2'b0, txh});
    qd <= 30'h200;
    run(4000);
    chk("tx pick", 32'h200, {2'b0, txh});
    mux <= 1'b1;
    rxr <= 30'h2000_0000;
    txr <= 30'h0400_0000;
    qd <= '1;
    avs(1'b1, OFS_MAP, 32'h3FFF_FFFF);
    avs(1'b1, OFS_CTRL, 32'h0000_0003);
    // cells chosen under the old mode must drain before tracking starts
    run(1200);
    run(4000);
    chk("mux rx pick", 32'h2000_0000, {2'b0, rxh});
    chk("mux tx pick", 32'h0400_0000, {2'b0, txh});
    chk("mux rx seen", 32'h3111_1111, rxs & 32'h7FFF_FFFF);
    chk("mux tx seen", 32'h1511_1111, txs & 32'h7FFF_FFFF);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("reset addr", {27'h0, NULL_ADDR}, {27'h0, rxa});
    chk("reset enable", 32'h0, {31'h0, txe});
    avs(1'b0, OFS_CTRL, '0);
    chk("ctrl after reset", CTRL_RST, q);
    avs(1'b0, OFS_STATUS, '0);
    chk("status after reset", {3'h0, NULL_ADDR, 11'h000, NULL_ADDR, 8'h00}, q);
    wrap_up();
  end
endmodule
